// file: parallel_host_port.sv
/*
  Pin-level parallel host port with general-purpose I/O fallback.
  Written host data other than control-register writes passes through a FIFO to the core side, and is dropped while the FIFO is full; the core
  supplies read data and a service request. Assumes host pins are
  synchronous to mclk_i.
*/
// Contract
// - The device offers an 8-bit data port to the host bus.
// - With the port active and the strobe and acknowledge high, data pins are undriven.
// - Strobe low with direction high drives read data onto the pins.
// - Strobe low with direction low leaves the pins as inputs.
// - Write data is captured on the rising edge of the strobe.
// - Acknowledge low while request is asserted also drives the pins.
// - The service request is driven open-drain.
// - Unselected, all pins are GPIO and the request pin is push-pull.
// - After reset all shared pins are GPIO inputs.
`timescale 1ns/10ps
`include "host_port_defs.svh"
module parallel_host_port
  import host_port_pkg::*;
#(
  parameter int DATA_W     = `HP_DATA_W,
  parameter int FIFO_DEPTH = `HP_FIFO_DEPTH
)
(
  input  wire logic                  mclk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  port_select_i,
  input  wire logic [`HP_GPIO_W-1:0] gpio_out_i,
  input  wire logic [`HP_GPIO_W-1:0] gpio_dir_i,
  output logic      [`HP_GPIO_W-1:0] gpio_in_o,
  input  wire logic [`HP_GPIO_W-1:0] pin_i,
  output logic      [`HP_GPIO_W-1:0] pin_o,
  output logic      [`HP_GPIO_W-1:0] pin_oe_o,
  input  wire logic [DATA_W-1:0]     core_rd_data_i,
  input  wire logic                  core_req_i,
  output logic                       core_wr_valid_o,
  output logic      [DATA_W-1:0]     core_wr_data_o,
  input  wire logic                  core_wr_ready_i,
  output logic      [`HP_SEL_W-1:0]  core_wr_sel_o,
  output logic      [DATA_W-1:0]     ctrl_o,
  output logic                       ack_pulse_o
);
  initial
  begin
    if (DATA_W != 8)
      $error("parallel_host_port: data width must be 8");
  end

  stream_if #(.W(DATA_W + `HP_SEL_W)) wr_in ();
  stream_if #(.W(DATA_W + `HP_SEL_W)) wr_out ();

  host_fifo #(.W(DATA_W + `HP_SEL_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .in_s   (wr_in),
    .out_s  (wr_out)
  );

  logic [DATA_W-1:0]    host_data_pins;
  logic [`HP_SEL_W-1:0] host_register_select;
  logic                 host_transfer_direction;
  logic                 host_transfer_strobe_n;
  logic                 host_acknowledge_n;

  always_comb
  begin
    host_data_pins          = pin_i[`HP_GPIO_DATA_LSB +: DATA_W];
    host_register_select    = pin_i[`HP_GPIO_ADDR_LSB +: `HP_SEL_W];
    host_transfer_direction = pin_i[`HP_GPIO_DIR_BIT];
    host_transfer_strobe_n  = pin_i[`HP_GPIO_STB_BIT];
    host_acknowledge_n      = pin_i[`HP_GPIO_ACK_BIT];
  end

  xfer_state_t          state;
  xfer_state_t          next_state;
  logic                 active;
  logic                 next_active;
  logic [DATA_W-1:0]    wr_data;
  logic [DATA_W-1:0]    next_wr_data;
  logic [`HP_SEL_W-1:0] wr_sel;
  logic [`HP_SEL_W-1:0] next_wr_sel;
  logic                 wr_pend;
  logic                 next_wr_pend;
  logic [DATA_W-1:0]    ctrl;
  logic [DATA_W-1:0]    next_ctrl;
  logic                 ack_d;
  logic [`HP_GPIO_W-1:0] next_pin_o;
  logic [`HP_GPIO_W-1:0] next_pin_oe;
  logic [DATA_W-1:0]    rd_mux;
  logic                 drive_data;
  logic                 strobe_rise;

  // Register select decode for reads
  always_comb
  begin
    case (host_register_select)
      `HP_SEL_DATA:   rd_mux = core_rd_data_i;
      `HP_SEL_STATUS: rd_mux = {{(DATA_W-2){1'b0}}, wr_in.ready, core_req_i};
      `HP_SEL_CTRL:   rd_mux = ctrl;
      default:        rd_mux = '0;
    endcase
  end

  // Transfer tracking and write capture
  always_comb
  begin
    next_active  = port_select_i;
    next_state   = state;
    next_wr_data = wr_data;
    next_wr_sel  = wr_sel;
    next_wr_pend = 1'b0;
    next_ctrl    = ctrl;
    strobe_rise  = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (active && !host_transfer_strobe_n)
          next_state = host_transfer_direction ? ST_READ : ST_WRITE;
      end
      ST_READ:
      begin
        if (host_transfer_strobe_n || !active)
          next_state = ST_IDLE;
      end
      ST_WRITE:
      begin
        next_wr_data = host_data_pins;
        next_wr_sel  = host_register_select;
        if (!active)
          next_state = ST_IDLE;
        else if (host_transfer_strobe_n)
        begin
          next_state  = ST_IDLE;
          strobe_rise = 1'b1;
          next_wr_data = wr_data;
          next_wr_sel  = wr_sel;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
    if (strobe_rise)
    begin
      if (wr_sel == `HP_SEL_CTRL)
        next_ctrl = wr_data;
      else
        next_wr_pend = 1'b1;
    end
  end

  assign wr_in.valid  = wr_pend;
  assign wr_in.data   = {wr_sel, wr_data};
  assign wr_out.ready = core_wr_ready_i;

  // Pin drive: host mode vs GPIO mode
  always_comb
  begin
    drive_data = !host_transfer_strobe_n && host_transfer_direction;
    drive_data = drive_data || (!host_acknowledge_n && core_req_i);
    if (active)
    begin
      next_pin_o  = gpio_out_i;
      next_pin_oe = '0;
      next_pin_o[`HP_GPIO_DATA_LSB +: DATA_W]  = rd_mux;
      next_pin_oe[`HP_GPIO_DATA_LSB +: DATA_W] = {DATA_W{drive_data}};
      next_pin_o[`HP_GPIO_REQ_BIT]  = 1'b0;
      next_pin_oe[`HP_GPIO_REQ_BIT] = core_req_i;
    end
    else
    begin
      next_pin_o  = gpio_out_i;
      next_pin_oe = gpio_dir_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      state           <= ST_IDLE;
      active          <= 1'b0;
      wr_data         <= '0;
      wr_sel          <= '0;
      wr_pend         <= 1'b0;
      ctrl            <= `HP_CTRL_RESET;
      ack_d           <= 1'b1;
      pin_o           <= `HP_GPIO_RESET;
      pin_oe_o        <= `HP_GPIO_RESET;
      gpio_in_o       <= `HP_GPIO_RESET;
      core_wr_valid_o <= 1'b0;
      core_wr_data_o  <= '0;
      core_wr_sel_o   <= '0;
      ctrl_o          <= `HP_CTRL_RESET;
      ack_pulse_o     <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      active          <= next_active;
      wr_data         <= next_wr_data;
      wr_sel          <= next_wr_sel;
      wr_pend         <= next_wr_pend && wr_in.ready;
      ctrl            <= next_ctrl;
      ack_d           <= host_acknowledge_n;
      pin_o           <= next_pin_o;
      pin_oe_o        <= next_pin_oe;
      gpio_in_o       <= pin_i;
      core_wr_valid_o <= wr_out.valid;
      core_wr_data_o  <= wr_out.data[DATA_W-1:0];
      core_wr_sel_o   <= wr_out.data[DATA_W +: `HP_SEL_W];
      ctrl_o          <= ctrl;
      ack_pulse_o     <= active && ack_d && !host_acknowledge_n;
    end
  end
endmodule

// file: host_port_defs.svh
/*
  Constants for the parallel host port: pin counts, register select codes,
  pin group positions and reset values.
  Assumes inclusion by bare name from design files.
*/
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

`define HP_DATA_W        8
`define HP_SEL_W         3
`define HP_GPIO_W        15
`define HP_FIFO_DEPTH    4
`define HP_SEL_DATA      3'h0
`define HP_SEL_STATUS    3'h1
`define HP_SEL_CTRL      3'h2
`define HP_GPIO_DATA_LSB 0
`define HP_GPIO_ADDR_LSB 8
`define HP_GPIO_DIR_BIT  11
`define HP_GPIO_STB_BIT  12
`define HP_GPIO_REQ_BIT  13
`define HP_GPIO_ACK_BIT  14
`define HP_GPIO_RESET    15'h0000
`define HP_CTRL_RESET    8'h00

`endif

// file: host_port_pkg.sv
/*
  Types for the parallel host port.
  Assumes host_port_defs.svh is compiled alongside.
*/
package host_port_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } xfer_state_t;
endpackage

// file: stream_if.sv
/*
  Valid/ready stream carrier between the host port and its FIFO.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// file: host_fifo.sv
/*
  Synchronous FIFO with parameter width and depth, valid/ready both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module host_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
)
(
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  stream_if.dst     in_s,
  stream_if.src     out_s
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("host_fifo: depth must be a power of two >= 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  logic [AW:0]  next_wptr;
  logic [AW:0]  next_rptr;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  always_comb
  begin
    empty     = (wptr == rptr);
    full      = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
    push      = in_s.valid && !full;
    pop       = out_s.ready && !empty;
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
  end

  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rptr[AW-1:0]];

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wptr[AW-1:0]] <= in_s.data;
  end
endmodule

// file: parallel_host_port_assertions.sv
/* Pin checks for the parallel host port.
   Assumes binding to parallel_host_port. */
`timescale 1ns/10ps
module parallel_host_port_assertions
(
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        port_select_i,
  input wire logic [14:0] gpio_out_i,
  input wire logic [14:0] gpio_dir_i,
  input wire logic [14:0] gpio_in_o,
  input wire logic [14:0] pin_i,
  input wire logic [14:0] pin_o,
  input wire logic [14:0] pin_oe_o,
  input wire logic [7:0]  core_rd_data_i,
  input wire logic        core_req_i,
  input wire logic        core_wr_valid_o,
  input wire logic [7:0]  ctrl_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence rd_s;
    (port_select_i && !pin_i[12] && pin_i[11] && pin_i[10:8] == 3'h0)[*2];
  endsequence
  property cap_p;
    $rose(pin_i[12]) && port_select_i && !pin_i[11] && pin_i[10:8] == 3'h2
      && !$past(pin_i[12], 2) && $past(port_select_i)
      && $past(port_select_i, 2) && $past(port_select_i, 3)
      |-> ##2 ctrl_o == $past(pin_i[7:0], 3);
  endproperty
  AST_IDLE_HIZ: assert property (port_select_i && $past(port_select_i)
    && $past(port_select_i, 2) && $past(pin_i[12]) && $past(pin_i[14])
    |-> pin_oe_o[7:0] == 8'h00)
    else $error("data pins driven while idle");
  AST_READ_DRIVE: assert property (rd_s |=> pin_oe_o[7:0] == 8'hFF
    && pin_o[7:0] == $past(core_rd_data_i)) else $error("read not driven");
  AST_WRITE_INPUT: assert property ((port_select_i && !pin_i[12]
    && !pin_i[11] && pin_i[14])[*2] |=> pin_oe_o[7:0] == 8'h00)
    else $error("data pins driven on write");
  AST_CAPTURE: assert property (cap_p)
    else $error("control byte not captured");
  AST_ACK_DRIVE: assert property ((port_select_i && !pin_i[14]
    && core_req_i)[*2] |=> pin_oe_o[7:0] == 8'hFF)
    else $error("acknowledge did not drive data");
  AST_REQ_OPEN_DRAIN: assert property (port_select_i
    && $past(port_select_i) && $past(port_select_i, 2) && $past(nrst_i)
    |-> !pin_o[13] && pin_oe_o[13] == $past(core_req_i))
    else $error("request not open-drain");
  AST_GPIO_MODE: assert property (!port_select_i
    && !$past(port_select_i) && !$past(port_select_i, 2) && $past(nrst_i)
    |-> pin_oe_o == $past(gpio_dir_i) && pin_o == $past(gpio_out_i))
    else $error("general pins not following");
  AST_GPIO_IN: assert property ($past(nrst_i)
    |-> gpio_in_o == $past(pin_i)) else $error("pin input copy wrong");
  AST_RESET_INPUT: assert property (!$past(nrst_i)
    |-> pin_oe_o == 15'h0000 && !core_wr_valid_o)
    else $error("pins driven after reset");
  cover property (rd_s);
  cover property ($rose(core_wr_valid_o));
  cover property (port_select_i && !pin_i[14] && core_req_i);
endmodule
bind parallel_host_port parallel_host_port_assertions
  i_parallel_host_port_assertions (.*);

// file: host_model.sv
/* Host processor model driving strobe, direction, select and data.
   Assumes pin_i is the resolved pin level. */
`timescale 1ns/10ps
module host_model
(
  input  wire logic        mclk_i,
  input  wire logic [14:0] pin_i,
  output logic      [14:0] host_o
);
  initial host_o = 15'h7000;
  task xfer(input logic rd, input logic [2:0] sel, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge mclk_i);
    host_o[11:8] = {rd, sel};
    host_o[7:0] = rd ? ~d : d;
    host_o[12] = 1'b0;
    repeat (3) @(negedge mclk_i);
    q = pin_i[7:0];
    host_o[12] = 1'b1;
    host_o[7:0] = ~host_o[7:0];
    @(negedge mclk_i);
  endtask
  task ack(output logic [7:0] q);
    @(negedge mclk_i);
    host_o[14] = 1'b0;
    repeat (3) @(negedge mclk_i);
    q = pin_i[7:0];
    host_o[14] = 1'b1;
    @(negedge mclk_i);
  endtask
endmodule

// file: parallel_host_port_tb_top.sv
/* Testbench for the parallel host port.
   Assumes host_model on the pins and a pass-through pin resolution. */
`timescale 1ns/10ps
module parallel_host_port_tb_top;
  logic mclk_i, nrst_i, port_select_i, core_req_i, core_wr_ready_i;
  logic core_wr_valid_o, ack_pulse_o;
  logic [14:0] gpio_out_i, gpio_dir_i, gpio_in_o, pin_o, pin_oe_o, host_o;
  logic [7:0]  core_rd_data_i, core_wr_data_o, ctrl_o, q, e;
  logic [2:0]  core_wr_sel_o;
  wire  [14:0] pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & host_o);
  int err_count = 0;
  int tests_run = 0;
  logic [3:0] ack_cnt = 4'h0;
  always @(negedge mclk_i)
    if (ack_pulse_o === 1'b1)
      ack_cnt <= ack_cnt + 4'h1;
  parallel_host_port i_parallel_host_port (.*);
  host_model i_host_model (.mclk_i, .pin_i, .host_o);
  always #50 mclk_i = ~mclk_i;
  task check(input logic [14:0] seen, input logic [14:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task t_reset;
    check(pin_oe_o, 15'h0000);
    @(negedge mclk_i);
    check(gpio_in_o, pin_i);
  endtask
  task t_gpio;
    gpio_dir_i = 15'h7FFF;
    gpio_out_i = 15'h2A55;
    repeat (2) @(negedge mclk_i);
    check(pin_oe_o, 15'h7FFF);
    check(pin_o, 15'h2A55);
    gpio_dir_i = 15'h0000;
    repeat (2) @(negedge mclk_i);
    check(pin_oe_o, 15'h0000);
  endtask
  task t_read;
    port_select_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    check(pin_oe_o[7:0], 8'h00);
    i_host_model.xfer(1'b1, 3'h0, 8'h00, q);
    check(q, 8'hA5);
    i_host_model.xfer(1'b1, 3'h1, 8'h00, q);
    check(q, 8'h02);
    i_host_model.xfer(1'b1, 3'h5, 8'h00, q);
    check(q, 8'h00);
  endtask
  task t_write;
    i_host_model.xfer(1'b0, 3'h2, 8'h3C, q);
    repeat (2) @(negedge mclk_i);
    check(ctrl_o, 8'h3C);
    i_host_model.xfer(1'b1, 3'h2, 8'h3C, q);
    check(q, 8'h3C);
    e = 8'h00;
    repeat (5)
    begin
      e = e + 8'h11;
      i_host_model.xfer(1'b0, 3'h0, e, q);
    end
    repeat (4) @(negedge mclk_i);
    e = 8'h00;
    repeat (4)
    begin
      e = e + 8'h11;
      check(core_wr_valid_o, 1'b1);
      check(core_wr_data_o, e);
      check(core_wr_sel_o, 3'h0);
      core_wr_ready_i = 1'b1;
      @(negedge mclk_i);
      core_wr_ready_i = 1'b0;
      repeat (2) @(negedge mclk_i);
    end
    check(core_wr_valid_o, 1'b0);
  endtask
  task t_ack;
    core_req_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    check(pin_oe_o[13], 1'b1);
    check(pin_o[13], 1'b0);
    i_host_model.ack(q);
    check(q, 8'hA5);
    check(ack_cnt, 4'h1);
    core_req_i = 1'b0;
  endtask
  initial
  begin
    #2000000;
    err_count++;
    summarize;
  end
  initial
  begin
    mclk_i = 1'b0;
    nrst_i = 1'b0;
    port_select_i = 1'b0;
    gpio_out_i = 15'h0000;
    gpio_dir_i = 15'h0000;
    core_rd_data_i = 8'hA5;
    core_req_i = 1'b0;
    core_wr_ready_i = 1'b0;
    repeat (16) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_reset;
    t_gpio;
    t_read;
    t_write;
    t_ack;
    summarize;
  end
endmodule
